// *** cmp_params.svh ***
`ifndef CMP_PARAMS_SVH
`define CMP_PARAMS_SVH
// register addresses on the special-function bus
`define CMP1_CTRL_ADDR 8'h9a
`define CMP0_CTRL_ADDR 8'h9b
`define CMP1_MODE_ADDR 8'h9c
`define CMP0_MODE_ADDR 8'h9d
`define CMP1_SEL_ADDR 8'h9e
`define CMP0_SEL_ADDR 8'h9f
// control register fields
`define CTL_ON_BIT 7
`define CTL_RESULT_BIT 6
`define CTL_RISE_BIT 5
`define CTL_FALL_BIT 4
`define CTL_PHYS_HI 3
`define CTL_PHYS_LO 2
`define CTL_NHYS_HI 1
`define CTL_NHYS_LO 0
`define CTL_RESET 8'h00
// mode register fields
`define MODE_RISE_EN_BIT 5
`define MODE_FALL_EN_BIT 4
`define MODE_SPEED_HI 1
`define MODE_SPEED_LO 0
`define MODE_RESET 8'h02
`define MODE_WMASK 8'h33
// input select fields
`define SEL_NEG_HI 5
`define SEL_NEG_LO 4
`define SEL_POS_HI 1
`define SEL_POS_LO 0
`define SEL_RESET 8'h00
`define SEL_WMASK 8'h33
`define READ_IDLE 8'h00
`endif

// *** cmp_pkg.sv ***
package cmp_pkg;
    typedef logic [7:0] byte_t;
    // hysteresis amount per two-bit code
    typedef enum logic [1:0] {
        HYST_OFF = 2'b00,
        HYST_5MV = 2'b01,
        HYST_10MV = 2'b10,
        HYST_20MV = 2'b11
    } hyst_e;
    // response time mode, 100/175/320/1050 ns typical
    typedef enum logic [1:0] {
        SPEED_100NS = 2'b00,
        SPEED_175NS = 2'b01,
        SPEED_320NS = 2'b10,
        SPEED_1050NS = 2'b11
    } speed_e;
endpackage

// *** cmp_channel.sv ***
`timescale 1ns/100ps
`include "cmp_params.svh"
module cmp_channel
    import cmp_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    // analog result and enable
    input wire logic raw_i,
    input wire logic on_i,
    // software clears, one-cycle
    input wire logic clr_rise_i,
    input wire logic clr_fall_i,
    // status
    output logic result_o,
    output logic rise_flag_o,
    output logic fall_flag_o,
    output logic sync_out_o
);
    logic meta_q, meta_d;
    logic sync_q, sync_d;
    logic prev_q, prev_d;
    logic rise_q, rise_d;
    logic fall_q, fall_d;
    logic rise_evt, fall_evt;

    assign rise_evt = sync_q & ~prev_q;
    assign fall_evt = ~sync_q & prev_q;

    always_comb begin
        meta_d = raw_i & on_i;
        sync_d = meta_q;
        prev_d = sync_q;
        rise_d = rise_evt | (rise_q & ~clr_rise_i);
        fall_d = fall_evt | (fall_q & ~clr_fall_i);
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end else if (clk_en_i) begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
            rise_q <= rise_d;
            fall_q <= fall_d;
        end
    end

    assign result_o = sync_q;
    assign rise_flag_o = rise_q;
    assign fall_flag_o = fall_q;
    assign sync_out_o = sync_q;

    sticky_rise_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        rise_q && clk_en_i && !clr_rise_i |=> rise_q) else $error("rise flag lost");
    rise_set_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        clk_en_i && sync_q && !prev_q |=> rise_q) else $error("rise flag not set");
    fall_set_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        clk_en_i && !sync_q && prev_q |=> fall_q) else $error("fall flag not set");
    // result follows raw in two
    // both flops must have moved, so enables one and two cycles back
    sync_lat_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        clk_en_i ##1 clk_en_i |=> sync_q == $past(raw_i & on_i, 2))
        else $error("sync latency wrong");
endmodule

// *** cmp_control.sv ***
`timescale 1ns/100ps
`include "cmp_params.svh"
module cmp_control
    import cmp_pkg::*;
(
    // clock, reset, enable
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // analog core results, asynchronous
    input wire logic [1:0] cmp_raw_i,
    // analog core controls
    output logic [1:0] cmp_on_o,
    output logic [1:0] cmp_pos_hyst_o [2],
    output logic [1:0] cmp_neg_hyst_o [2],
    output logic [1:0] cmp_speed_sel_o [2],
    output logic [3:0] cmp_pos_pin_o [2],
    output logic [3:0] cmp_neg_pin_o [2],
    // pin outputs
    output logic [1:0] cmp_async_o,
    output logic [1:0] cmp_sync_o,
    // interrupt requests
    output logic [1:0] cmp_irq_o
);
    byte_t ctrl_q [2];
    byte_t ctrl_d [2];
    byte_t mode_q [2];
    byte_t mode_d [2];
    byte_t sel_q [2];
    byte_t sel_d [2];
    byte_t rdata_q, rdata_d;
    logic [1:0] result, rise_flag, fall_flag, sync_out;
    logic [1:0] clr_rise, clr_fall;
    logic [1:0] ctrl_hit, mode_hit, sel_hit;

    // one-hot pin select of a two-bit mux code
    function automatic logic [3:0] pin_onehot(input logic [1:0] code);
        pin_onehot = 4'h1 << code;
    endfunction

    always_comb begin
        ctrl_hit = 2'b00;
        mode_hit = 2'b00;
        sel_hit = 2'b00;
        if (reg_addr_i == `CMP0_CTRL_ADDR) begin
            ctrl_hit[0] = 1'b1;
        end else if (reg_addr_i == `CMP1_CTRL_ADDR) begin
            ctrl_hit[1] = 1'b1;
        end else if (reg_addr_i == `CMP0_MODE_ADDR) begin
            mode_hit[0] = 1'b1;
        end else if (reg_addr_i == `CMP1_MODE_ADDR) begin
            mode_hit[1] = 1'b1;
        end else if (reg_addr_i == `CMP0_SEL_ADDR) begin
            sel_hit[0] = 1'b1;
        end else if (reg_addr_i == `CMP1_SEL_ADDR) begin
            sel_hit[1] = 1'b1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : chan
            cmp_channel u_chan (
                .clk_sys_i(clk_sys_i),
                .reset_i(reset_i),
                .clk_en_i(clk_en_i),
                .raw_i(cmp_raw_i[g]),
                .on_i(ctrl_q[g][`CTL_ON_BIT]),
                .clr_rise_i(clr_rise[g]),
                .clr_fall_i(clr_fall[g]),
                .result_o(result[g]),
                .rise_flag_o(rise_flag[g]),
                .fall_flag_o(fall_flag[g]),
                .sync_out_o(sync_out[g])
            );

            assign clr_rise[g] = reg_wr_i & ctrl_hit[g] & ~reg_wdata_i[`CTL_RISE_BIT];
            assign clr_fall[g] = reg_wr_i & ctrl_hit[g] & ~reg_wdata_i[`CTL_FALL_BIT];

            always_comb begin
                ctrl_d[g] = ctrl_q[g];
                mode_d[g] = mode_q[g];
                sel_d[g] = sel_q[g];
                if (reg_wr_i && ctrl_hit[g]) begin
                    ctrl_d[g] = reg_wdata_i;
                end
                if (reg_wr_i && mode_hit[g]) begin
                    mode_d[g] = reg_wdata_i & `MODE_WMASK;
                end
                if (reg_wr_i && sel_hit[g]) begin
                    sel_d[g] = reg_wdata_i & `SEL_WMASK;
                end
            end

            always_ff @(posedge clk_sys_i) begin
                if (reset_i) begin
                    ctrl_q[g] <= `CTL_RESET;
                    mode_q[g] <= `MODE_RESET;
                    sel_q[g] <= `SEL_RESET;
                end else if (clk_en_i) begin
                    ctrl_q[g] <= ctrl_d[g];
                    mode_q[g] <= mode_d[g];
                    sel_q[g] <= sel_d[g];
                end
            end

            assign cmp_on_o[g] = ctrl_q[g][`CTL_ON_BIT];
            assign cmp_pos_hyst_o[g] = ctrl_q[g][`CTL_PHYS_HI:`CTL_PHYS_LO];
            assign cmp_neg_hyst_o[g] = ctrl_q[g][`CTL_NHYS_HI:`CTL_NHYS_LO];
            assign cmp_speed_sel_o[g] = mode_q[g][`MODE_SPEED_HI:`MODE_SPEED_LO];
            assign cmp_neg_pin_o[g] = pin_onehot(sel_q[g][`SEL_NEG_HI:`SEL_NEG_LO]);
            assign cmp_pos_pin_o[g] = pin_onehot(sel_q[g][`SEL_POS_HI:`SEL_POS_LO]);
            // raw path has no flop, works without clock
            assign cmp_async_o[g] = cmp_raw_i[g] & ctrl_q[g][`CTL_ON_BIT];
            assign cmp_sync_o[g] = sync_out[g] & ctrl_q[g][`CTL_ON_BIT];
            // rise enable on mode bit 5
            // fall enable on mode bit 4
            assign cmp_irq_o[g] = (rise_flag[g] & mode_q[g][`MODE_RISE_EN_BIT])
                | (fall_flag[g] & mode_q[g][`MODE_FALL_EN_BIT]);

            off_low_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
                !ctrl_q[g][`CTL_ON_BIT] |-> !cmp_async_o[g] && !cmp_sync_o[g])
                else $error("disabled output not low");
            rise_irq_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
                rise_flag[g] && mode_q[g][`MODE_RISE_EN_BIT] |-> cmp_irq_o[g])
                else $error("rise irq missing");
            fall_irq_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
                fall_flag[g] && mode_q[g][`MODE_FALL_EN_BIT] |-> cmp_irq_o[g])
                else $error("fall irq missing");
            irq_quiet_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
                !(rise_flag[g] && mode_q[g][`MODE_RISE_EN_BIT])
                && !(fall_flag[g] && mode_q[g][`MODE_FALL_EN_BIT]) |-> !cmp_irq_o[g])
                else $error("spurious irq");
            unused_zero_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
                ((mode_q[g] | sel_q[g]) & ~`MODE_WMASK) == 8'h00)
                else $error("unused bits set");
            enable_write_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
                clk_en_i && reg_wr_i && ctrl_hit[g] |=>
                cmp_on_o[g] == $past(reg_wdata_i[`CTL_ON_BIT]))
                else $error("enable not stored");
            pos_hyst_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
                clk_en_i && reg_wr_i && ctrl_hit[g] |=>
                cmp_pos_hyst_o[g] == $past(reg_wdata_i[`CTL_PHYS_HI:`CTL_PHYS_LO]))
                else $error("positive hysteresis not stored");
            neg_hyst_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
                clk_en_i && reg_wr_i && ctrl_hit[g] |=>
                cmp_neg_hyst_o[g] == $past(reg_wdata_i[`CTL_NHYS_HI:`CTL_NHYS_LO]))
                else $error("negative hysteresis not stored");
            speed_write_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
                clk_en_i && reg_wr_i && mode_hit[g] |=>
                cmp_speed_sel_o[g] == $past(reg_wdata_i[`MODE_SPEED_HI:`MODE_SPEED_LO]))
                else $error("response mode not stored");
            rise_en_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
                clk_en_i && reg_wr_i && mode_hit[g] |=>
                mode_q[g][`MODE_RISE_EN_BIT] == $past(reg_wdata_i[`MODE_RISE_EN_BIT]))
                else $error("rise enable not stored");
            fall_en_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
                clk_en_i && reg_wr_i && mode_hit[g] |=>
                mode_q[g][`MODE_FALL_EN_BIT] == $past(reg_wdata_i[`MODE_FALL_EN_BIT]))
                else $error("fall enable not stored");
            neg_pin_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
                clk_en_i && reg_wr_i && sel_hit[g] |=>
                cmp_neg_pin_o[g] == (4'h1 << $past(reg_wdata_i[`SEL_NEG_HI:`SEL_NEG_LO])))
                else $error("negative pin select wrong");
            pos_pin_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
                clk_en_i && reg_wr_i && sel_hit[g] |=>
                cmp_pos_pin_o[g] == (4'h1 << $past(reg_wdata_i[`SEL_POS_HI:`SEL_POS_LO])))
                else $error("positive pin select wrong");
            pin_onehot_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
                $onehot(cmp_pos_pin_o[g]) && $onehot(cmp_neg_pin_o[g]))
                else $error("pin select not one-hot");
            async_follow_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
                ctrl_q[g][`CTL_ON_BIT] |->
                cmp_async_o[g] == cmp_raw_i[g])
                else $error("raw output not following");
            sync_follow_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
                ctrl_q[g][`CTL_ON_BIT] |->
                cmp_sync_o[g] == result[g])
                else $error("synced output not following");
            sel_read_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
                clk_en_i && reg_rd_i && sel_hit[g] |=>
                (reg_rdata_o & ~`SEL_WMASK) == `READ_IDLE)
                else $error("select spare bits set");
            mode_read_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
                clk_en_i && reg_rd_i && mode_hit[g] |=>
                (reg_rdata_o & ~`MODE_WMASK) == `READ_IDLE)
                else $error("mode spare bits set");
            // flags at same bits both channels
            flag_read_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
                clk_en_i && reg_rd_i && ctrl_hit[g] |=>
                reg_rdata_o[`CTL_RISE_BIT] == $past(rise_flag[g])
                && reg_rdata_o[`CTL_FALL_BIT] == $past(fall_flag[g]))
                else $error("flag read wrong");
            on_read_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
                clk_en_i && reg_rd_i && ctrl_hit[g] |=>
                reg_rdata_o[`CTL_ON_BIT] == $past(cmp_on_o[g]))
                else $error("enable read wrong");
            sticky_fall_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
                fall_flag[g] && clk_en_i && !clr_fall[g] |=>
                fall_flag[g])
                else $error("fall flag lost");
        end
    endgenerate

    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd_i) begin
            rdata_d = `READ_IDLE;
            for (int i = 0; i < 2; i++) begin
                if (ctrl_hit[i]) begin
                    rdata_d = ctrl_q[i];
                    rdata_d[`CTL_RESULT_BIT] = result[i];
                    rdata_d[`CTL_RISE_BIT] = rise_flag[i];
                    rdata_d[`CTL_FALL_BIT] = fall_flag[i];
                end else if (mode_hit[i]) begin
                    rdata_d = mode_q[i];
                end else if (sel_hit[i]) begin
                    rdata_d = sel_q[i];
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            rdata_q <= `READ_IDLE;
        end else if (clk_en_i) begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_o = rdata_q;

    mode_reset_a: assert property (@(posedge clk_sys_i)
        reset_i ##1 !reset_i |-> mode_q[0] == `MODE_RESET && mode_q[1] == `MODE_RESET)
        else $error("mode reset wrong");
    read_result_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        clk_en_i && reg_rd_i && ctrl_hit[0] |=> reg_rdata_o[`CTL_RESULT_BIT] == $past(result[0]))
        else $error("result bit wrong");
endmodule

// *** analog_src.sv ***
`timescale 1ns/100ps
module analog_src (
    // wanted comparison outcome per channel
    input wire logic [1:0] level_i,
    // response time mode per channel
    input wire logic [1:0] speed_sel_i [2],
    // raw comparator results
    output logic [1:0] raw_o
);
    function automatic realtime settle(input logic [1:0] m);
        case (m)
            2'b00: return 100.0;
            2'b01: return 175.0;
            2'b10: return 320.0;
            default: return 1050.0;
        endcase
    endfunction

    // slow modes stretch the wait on the clocked side
    initial raw_o = 2'b00;
    always @(level_i[0]) raw_o[0] <= #(settle(speed_sel_i[0])) level_i[0];
    always @(level_i[1]) raw_o[1] <= #(settle(speed_sel_i[1])) level_i[1];
endmodule

// *** tb_top.sv ***
`timescale 1ns/100ps
`include "cmp_params.svh"
module tb_top;
    import cmp_pkg::*;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [7:0] reg_rdata_o;
    logic [1:0] raw;
    logic [1:0] level = 2'b00;
    logic clk_en = 1'b1;
    logic [1:0] cmp_on_o, cmp_async_o, cmp_sync_o, cmp_irq_o;
    logic [1:0] pos_hyst [2];
    logic [1:0] neg_hyst [2];
    logic [1:0] speed [2];
    logic [3:0] pos_pin [2];
    logic [3:0] neg_pin [2];
    logic [7:0] ctl_a [2] = '{`CMP0_CTRL_ADDR, `CMP1_CTRL_ADDR};
    logic [7:0] mode_a [2] = '{`CMP0_MODE_ADDR, `CMP1_MODE_ADDR};
    logic [7:0] sel_a [2] = '{`CMP0_SEL_ADDR, `CMP1_SEL_ADDR};
    int mismatches = 0;
    int total_checks = 0;

    cmp_control i_cmp_control (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .clk_en_i(clk_en),
        .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .cmp_raw_i(raw),
        .cmp_on_o(cmp_on_o), .cmp_pos_hyst_o(pos_hyst), .cmp_neg_hyst_o(neg_hyst),
        .cmp_speed_sel_o(speed), .cmp_pos_pin_o(pos_pin), .cmp_neg_pin_o(neg_pin),
        .cmp_async_o(cmp_async_o), .cmp_sync_o(cmp_sync_o), .cmp_irq_o(cmp_irq_o));
    analog_src i_analog_src (.level_i(level), .speed_sel_i(speed), .raw_o(raw));

    initial begin
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // idle cycle after each strobe keeps one assignment per time step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        @(posedge clk_sys_i);
        check(reg_rdata_o, exp);
    endtask

    // extra edge lets the flag land after the synced result
    task automatic wait_sync(input int i, input logic lvl);
        int n = 0;
        while (cmp_sync_o[i] !== lvl && n < 60) begin
            @(posedge clk_sys_i);
            n++;
        end
        if (n == 60) begin
            mismatches++;
            stop_test();
        end else begin
            @(posedge clk_sys_i);
        end
    endtask

    task automatic test_reset();
        for (int i = 0; i < 2; i++) begin
            rdchk(ctl_a[i], `CTL_RESET);
            rdchk(mode_a[i], `MODE_RESET);
            rdchk(sel_a[i], `SEL_RESET);
        end
        rdchk(8'h90, `READ_IDLE);
        check({6'h00, cmp_async_o}, 8'h00);
    endtask

    // frozen enable must drop a write
    task automatic test_hold();
        clk_en <= 1'b0;
        wr(mode_a[0], 8'h31);
        check({6'h00, speed[0]}, `MODE_RESET);
        clk_en <= 1'b1;
        rdchk(mode_a[0], `MODE_RESET);
    endtask

    // code 11 used, larger package assumed
    task automatic test_fields(input int i);
        for (logic [2:0] c = 3'h0; c < 3'h4; c++) begin
            wr(sel_a[i], 8'hcc | {2'b00, c[1:0], 2'b00, c[1:0]});
            rdchk(sel_a[i], {2'b00, c[1:0], 2'b00, c[1:0]});
            check({4'h0, pos_pin[i]}, 8'h01 << c);
            check({4'h0, neg_pin[i]}, 8'h01 << c);
            wr(mode_a[i], 8'hcc | {6'h00, c[1:0]});
            rdchk(mode_a[i], {6'h00, c[1:0]});
            check({6'h00, speed[i]}, {6'h00, c[1:0]});
            wr(ctl_a[i], {4'h8, c[1:0], ~c[1:0]});
            rdchk(ctl_a[i], {4'h8, c[1:0], ~c[1:0]});
            check({2'b00, pos_hyst[i], 2'b00, neg_hyst[i]}, {2'b00, c[1:0], 2'b00, ~c[1:0]});
            check({7'h00, cmp_on_o[i]}, 8'h01);
        end
        wr(ctl_a[i], 8'h70);
        rdchk(ctl_a[i], 8'h00);
    endtask

    task automatic test_edges(input int i);
        wr(mode_a[i], 8'h30);
        wr(ctl_a[i], 8'h80);
        level[i] <= 1'b1;
        wait_sync(i, 1'b1);
        check({7'h00, cmp_async_o[i]}, 8'h01);
        rdchk(ctl_a[i], 8'he0);
        check({7'h00, cmp_irq_o[i]}, 8'h01);
        level[i] <= 1'b0;
        wait_sync(i, 1'b0);
        rdchk(ctl_a[i], 8'hb0);
        wr(mode_a[i], 8'h20);
        check({7'h00, cmp_irq_o[i]}, 8'h01);
        wr(ctl_a[i], 8'h90);
        rdchk(ctl_a[i], 8'h90);
        check({7'h00, cmp_irq_o[i]}, 8'h00);
        wr(mode_a[i], 8'h10);
        check({7'h00, cmp_irq_o[i]}, 8'h01);
        wr(ctl_a[i], 8'h80);
        check({7'h00, cmp_irq_o[i]}, 8'h00);
        level[i] <= 1'b1;
        wait_sync(i, 1'b1);
        wr(ctl_a[i], 8'h00);
        check({7'h00, cmp_async_o[i]}, 8'h00);
        wait_sync(i, 1'b0);
        check({7'h00, cmp_sync_o[i]}, 8'h00);
        // clear meets the fall made by disabling: set wins
        wr(ctl_a[i], 8'h00);
        level[i] <= 1'b0;
        rdchk(ctl_a[i], 8'h10);
        wr(ctl_a[i], 8'h00);
        rdchk(ctl_a[i], 8'h00);
    endtask

    initial begin
        repeat (6) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        @(posedge clk_sys_i);
        test_reset();
        test_hold();
        for (int i = 0; i < 2; i++) begin
            test_fields(i);
            test_edges(i);
        end
        stop_test();
    end
endmodule
